// *** hdl/scad_params.svh ***
`ifndef SCAD_PARAMS_SVH
`define SCAD_PARAMS_SVH

// ------------------------------------------------------------
// Clock and frequency constants.
// ------------------------------------------------------------
`define SCAD_CLK_MHZ        100
`define SCAD_CLK_NS         10
`define SCAD_BASE_KHZ       8000
`define SCAD_N_MIN          8
`define SCAD_N_MAX          40
`define SCAD_N_STEP_NS      125
`define SCAD_F_LOW_KHZ      200
`define SCAD_F_OPEN_KHZ     400
`define SCAD_F_HIGH_KHZ     1000
`define SCAD_F_OUT_KHZ      400
`define SCAD_N_RST          20

// ------------------------------------------------------------
// Detection timing.
// ------------------------------------------------------------
`define SCAD_PER_MIN_NS     1000
`define SCAD_PER_MAX_NS     5000
`define SCAD_LOSS_NS        6000
`define SCAD_DET_WIN_US     50
`define SCAD_DET_EDGES      8
`define SCAD_PER_MIN_CYC    ((`SCAD_PER_MIN_NS * `SCAD_CLK_MHZ + 999) / 1000)
`define SCAD_PER_MAX_CYC    ((`SCAD_PER_MAX_NS * `SCAD_CLK_MHZ) / 1000)
`define SCAD_LOSS_CYC       ((`SCAD_LOSS_NS * `SCAD_CLK_MHZ + 999) / 1000)
`define SCAD_DET_WIN_CYC    (`SCAD_DET_WIN_US * `SCAD_CLK_MHZ)
`define SCAD_OUT_HALF_CYC   ((`SCAD_CLK_MHZ * 1000) / (2 * `SCAD_F_OUT_KHZ))

// ------------------------------------------------------------
// Widths and table size.
// ------------------------------------------------------------
`define SCAD_PER_W          13
`define SCAD_LUT_LAST       16

`endif

// *** hdl/scad_pkg.sv ***
package scad_pkg;

    typedef logic [9:0] scad_khz_t;
    typedef logic [5:0] scad_n_t;

    typedef enum logic [1:0] {
        SCAD_CFG_LOW  = 2'b00,
        SCAD_CFG_OPEN = 2'b01,
        SCAD_CFG_HIGH = 2'b10
    } scad_cfg_t;

    typedef enum logic [1:0] {
        SCAD_STRAP_LOW  = 2'b00,
        SCAD_STRAP_OPEN = 2'b01,
        SCAD_STRAP_HIGH = 2'b10,
        SCAD_STRAP_RES  = 2'b11
    } scad_strap_t;

    typedef enum logic [2:0] {
        SCAD_ST_IDLE     = 3'b000,
        SCAD_ST_DETECT   = 3'b001,
        SCAD_ST_PICK     = 3'b010,
        SCAD_ST_LOCKED   = 3'b011,
        SCAD_ST_INTERNAL = 3'b100
    } scad_state_t;

endpackage

// *** hdl/scad_res_lut.sv ***
`include "scad_params.svh"

module scad_res_lut (
    input  wire logic               clk_sys,
    input  wire logic               arst_n,
    input  wire logic [4:0]         addr,
    output scad_pkg::scad_khz_t     rd_khz
);

    scad_pkg::scad_khz_t rd_r;
    scad_pkg::scad_khz_t rd_nxt;

    // ------------------------------------------------------------
    // Resistor to frequency table, indices above the last clamp to it.
    // ------------------------------------------------------------
    always_comb begin
        case ((addr > 5'(`SCAD_LUT_LAST)) ? 5'(`SCAD_LUT_LAST) : addr) // R5
            5'h00:   rd_nxt = 10'h0c8;
            5'h01:   rd_nxt = 10'h0de;
            5'h02:   rd_nxt = 10'h0f2;
            5'h03:   rd_nxt = 10'h10b;
            5'h04:   rd_nxt = 10'h128;
            5'h05:   rd_nxt = 10'h140;
            5'h06:   rd_nxt = 10'h16c;
            5'h07:   rd_nxt = 10'h190;
            5'h08:   rd_nxt = 10'h1a5;
            5'h09:   rd_nxt = 10'h1d7;
            5'h0a:   rd_nxt = 10'h215;
            5'h0b:   rd_nxt = 10'h23b;
            5'h0c:   rd_nxt = 10'h267;
            5'h0d:   rd_nxt = 10'h29b;
            5'h0e:   rd_nxt = 10'h2d7;
            5'h0f:   rd_nxt = 10'h379;
            default: rd_nxt = 10'h3e8;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_r <= 10'h000;
        end else begin
            rd_r <= rd_nxt;
        end
    end

    assign rd_khz = rd_r;

endmodule

// *** hdl/scad_sync_edge.sv ***
module scad_sync_edge (
    input  wire logic clk_link,
    input  wire logic clk_sys,
    input  wire logic arst_n,
    output logic      edge_p
);

    logic tog_r;
    logic tog_nxt;
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic edge_r;
    logic edge_nxt;

    // ------------------------------------------------------------
    // Link side toggles once per rising edge of the incoming clock.
    // ------------------------------------------------------------
    always_comb begin
        tog_nxt = ~tog_r;
    end

    always_ff @(posedge clk_link or negedge arst_n) begin
        if (!arst_n) begin
            tog_r <= 1'b0;
        end else begin
            tog_r <= tog_nxt;
        end
    end

    // ------------------------------------------------------------
    // System side synchronises the toggle and turns it into a pulse.
    // ------------------------------------------------------------
    always_comb begin
        edge_nxt = s2_r ^ s3_r;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s1_r   <= 1'b0;
            s2_r   <= 1'b0;
            s3_r   <= 1'b0;
            edge_r <= 1'b0;
        end else begin
            s1_r   <= tog_r;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            edge_r <= edge_nxt;
        end
    end

    assign edge_p = edge_r;

endmodule

// *** hdl/scad_top.sv ***
// Operation
// [R1] In auto detect, probe the sync pin for a clock once enable rises.
// [R2] With a valid clock found, align the oscillator to its rising edges.
// [R3] No clock: pin low 200kHz, open 400kHz, high 1MHz, resistor from table.
// [R4] Sync pin strap is taken once after power-up, later changes ignored.
// [R5] Seventeen-entry resistor table maps 10k..46.4k to 200..1000 kHz.
// [R6] Host frequency is 8MHz divided by N, N from 8 to 40.
// [R7] A host value off the grid takes the nearest valid divided frequency.
// [R8] Read-back frequency is the quantised 8MHz/N value, not the table value.
// [R9] Exactly one shared-line converter drives sync, others input or auto.
// [R10] Precise ramp timing must stay off when auto detect is used.
// [R11] Config pin: low input, open auto detect, high drives 400kHz out.
// [R12] On clock loss, fall back to internal oscillator near last frequency.
// [R13] Clock valid after fixed count of in-range edges within a window.
`include "scad_params.svh"

module scad_top #(
    parameter logic [12:0] DET_WIN_CYC = 13'(`SCAD_DET_WIN_CYC)
) (
    input  wire logic               clk_sys,
    input  wire logic               arst_n,
    input  wire logic               clk_sync,
    input  wire logic               en_pin,
    input  wire logic [1:0]         cfg_pin,
    input  wire logic [1:0]         strap_pin,
    input  wire logic [4:0]         res_idx_pin,
    input  wire logic               host_wr,
    input  wire logic [9:0]         host_khz,
    output scad_pkg::scad_n_t       osc_n,
    output logic                    osc_sync_p,
    output logic                    ext_locked,
    output logic                    ext_lost,
    output scad_pkg::scad_khz_t     freq_khz,
    output logic                    sync_o,
    output logic                    sync_oe
);

    // ------------------------------------------------------------
    // Arithmetic helpers.
    // ------------------------------------------------------------
    function automatic scad_pkg::scad_n_t clamp_n(input logic [19:0] q);
        return (q < 20'(`SCAD_N_MIN)) ? 6'(`SCAD_N_MIN) : ((q > 20'(`SCAD_N_MAX)) ? 6'(`SCAD_N_MAX) : q[5:0]);
    endfunction
    function automatic scad_pkg::scad_n_t n_from_khz(input scad_pkg::scad_khz_t khz);
        logic [31:0] k;
        logic [31:0] q;
        k = (khz == 10'h000) ? 32'h00000001 : 32'(khz);
        q = 32'(`SCAD_BASE_KHZ) / k;
        if (32'(`SCAD_BASE_KHZ) * ((q << 1) + 32'h00000001) > ((k * q) << 1) * (q + 32'h00000001)) begin
            q = q + 32'h00000001;
        end
        return clamp_n(q[19:0]); // R7
    endfunction
    function automatic scad_pkg::scad_n_t n_from_per(input logic [`SCAD_PER_W-1:0] per);
        logic [19:0] ns2;
        ns2 = 20'(per) * 20'(2 * `SCAD_CLK_NS);
        return clamp_n((ns2 + 20'(`SCAD_N_STEP_NS)) / 20'(2 * `SCAD_N_STEP_NS));
    endfunction
    function automatic scad_pkg::scad_khz_t n_to_khz(input scad_pkg::scad_n_t n);
        return 10'(14'(`SCAD_BASE_KHZ) / 14'(n)); // R8
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------
    logic [1:0] en_q;
    logic [1:0] cfg_q1;
    logic [1:0] cfg_q2;
    logic [1:0] strap_q1;
    logic [1:0] strap_q2;
    logic [4:0] res_q1;
    logic [4:0] res_q2;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            en_q     <= 2'h0;
            cfg_q1   <= 2'h0;
            cfg_q2   <= 2'h0;
            strap_q1 <= 2'h0;
            strap_q2 <= 2'h0;
            res_q1   <= 5'h00;
            res_q2   <= 5'h00;
        end else begin
            en_q     <= {en_q[0], en_pin};
            cfg_q1   <= cfg_pin;
            cfg_q2   <= cfg_q1;
            strap_q1 <= strap_pin;
            strap_q2 <= strap_q1;
            res_q1   <= res_idx_pin;
            res_q2   <= res_q1;
        end
    end

    logic                   en_s;
    scad_pkg::scad_cfg_t    cfg_s;
    scad_pkg::scad_strap_t  strap_s;
    logic                   edge_p;
    scad_pkg::scad_khz_t    lut_khz;
    assign en_s    = en_q[1];
    assign cfg_s   = scad_pkg::scad_cfg_t'(cfg_q2);
    assign strap_s = scad_pkg::scad_strap_t'(strap_q2);
    scad_sync_edge u_edge (
        .clk_link (clk_sync),
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .edge_p   (edge_p)
    );
    scad_res_lut u_lut (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .addr    (res_q2),
        .rd_khz  (lut_khz)
    );

    // ------------------------------------------------------------
    // Detection and selection state.
    // ------------------------------------------------------------
    scad_pkg::scad_state_t      state_r,       state_nxt;
    logic [`SCAD_PER_W-1:0]     per_cnt_r,     per_cnt_nxt;
    logic [`SCAD_PER_W-1:0]     last_per_r,    last_per_nxt;
    logic                       have_prev_r,   have_prev_nxt;
    logic [3:0]                 edge_cnt_r,    edge_cnt_nxt;
    logic [12:0]                win_cnt_r,     win_cnt_nxt;
    scad_pkg::scad_n_t          n_r,           n_nxt;
    scad_pkg::scad_n_t          host_n_r,      host_n_nxt;
    logic                       host_set_r,    host_set_nxt;
    scad_pkg::scad_n_t          strap_n_r,     strap_n_nxt;
    logic                       strap_taken_r, strap_taken_nxt;
    logic                       locked_r,      locked_nxt;
    logic                       lost_r,        lost_nxt;
    logic                       osc_sync_r,    osc_sync_nxt;
    scad_pkg::scad_khz_t        freq_r,        freq_nxt;
    logic                       in_range;

    always_comb begin
        state_nxt       = state_r;
        per_cnt_nxt     = (&per_cnt_r) ? per_cnt_r : per_cnt_r + 1'b1;
        last_per_nxt    = last_per_r;
        have_prev_nxt   = have_prev_r;
        edge_cnt_nxt    = edge_cnt_r;
        win_cnt_nxt     = win_cnt_r;
        n_nxt           = n_r;
        host_n_nxt      = host_n_r;
        host_set_nxt    = host_set_r;
        strap_n_nxt     = strap_n_r;
        strap_taken_nxt = strap_taken_r;
        locked_nxt      = locked_r;
        lost_nxt        = lost_r;
        osc_sync_nxt    = 1'b0;
        in_range        = (per_cnt_r >= `SCAD_PER_W'(`SCAD_PER_MIN_CYC)) &&
                          (per_cnt_r <= `SCAD_PER_W'(`SCAD_PER_MAX_CYC));
        if (edge_p) begin
            per_cnt_nxt = '0;
        end
        if (host_wr) begin
            host_n_nxt   = n_from_khz(host_khz); // R6 R7
            host_set_nxt = 1'b1;
            if (state_r == scad_pkg::SCAD_ST_INTERNAL) begin
                n_nxt = n_from_khz(host_khz); // R6
            end
        end
        case (state_r)
            scad_pkg::SCAD_ST_IDLE: begin
                if (en_s && cfg_s == scad_pkg::SCAD_CFG_HIGH) begin
                    n_nxt     = n_from_khz(10'(`SCAD_F_OUT_KHZ)); // R11
                    state_nxt = scad_pkg::SCAD_ST_INTERNAL;
                end else if (en_s) begin
                    state_nxt     = scad_pkg::SCAD_ST_DETECT; // R1
                    have_prev_nxt = 1'b0;
                    edge_cnt_nxt  = 4'h0;
                    win_cnt_nxt   = 13'h0000;
                    lost_nxt      = 1'b0;
                end
            end
            scad_pkg::SCAD_ST_DETECT: begin
                win_cnt_nxt = win_cnt_r + 1'b1;
                if (edge_p) begin
                    have_prev_nxt = 1'b1;
                    edge_cnt_nxt  = (have_prev_r && in_range) ? edge_cnt_r + 1'b1 : 4'h0; // R13
                    last_per_nxt  = per_cnt_r;
                end
                if (edge_cnt_nxt == 4'(`SCAD_DET_EDGES)) begin
                    state_nxt  = scad_pkg::SCAD_ST_LOCKED; // R13
                    locked_nxt = 1'b1;
                end else if (win_cnt_r == DET_WIN_CYC - 1'b1) begin
                    state_nxt = scad_pkg::SCAD_ST_PICK;
                end
            end
            scad_pkg::SCAD_ST_PICK: begin
                if (cfg_s == scad_pkg::SCAD_CFG_OPEN && !strap_taken_r) begin
                    strap_taken_nxt = 1'b1; // R4
                    case (strap_s) // R3
                        scad_pkg::SCAD_STRAP_LOW:  strap_n_nxt = n_from_khz(10'(`SCAD_F_LOW_KHZ));
                        scad_pkg::SCAD_STRAP_OPEN: strap_n_nxt = n_from_khz(10'(`SCAD_F_OPEN_KHZ));
                        scad_pkg::SCAD_STRAP_HIGH: strap_n_nxt = n_from_khz(10'(`SCAD_F_HIGH_KHZ));
                        default:                   strap_n_nxt = n_from_khz(lut_khz); // R5
                    endcase
                end
                if (host_set_nxt) begin
                    n_nxt = host_n_nxt;
                end else if (cfg_s == scad_pkg::SCAD_CFG_OPEN) begin
                    n_nxt = strap_n_nxt; // R3
                end else begin
                    n_nxt = n_from_khz(10'(`SCAD_F_OPEN_KHZ));
                end
                state_nxt = scad_pkg::SCAD_ST_INTERNAL;
            end
            scad_pkg::SCAD_ST_LOCKED: begin
                if (edge_p) begin
                    last_per_nxt = per_cnt_r;
                    osc_sync_nxt = 1'b1; // R2
                end else if (per_cnt_r >= `SCAD_PER_W'(`SCAD_LOSS_CYC)) begin
                    n_nxt      = n_from_per(last_per_r); // R12
                    locked_nxt = 1'b0;
                    lost_nxt   = 1'b1;
                    state_nxt  = scad_pkg::SCAD_ST_INTERNAL;
                end
            end
            scad_pkg::SCAD_ST_INTERNAL: state_nxt = scad_pkg::SCAD_ST_INTERNAL;
            default: begin
                state_nxt = scad_pkg::SCAD_ST_IDLE;
            end
        endcase
        if (!en_s) begin
            state_nxt  = scad_pkg::SCAD_ST_IDLE; // R1
            locked_nxt = 1'b0;
        end
        freq_nxt = locked_nxt ? n_to_khz(n_from_per(last_per_nxt)) : n_to_khz(n_nxt); // R8
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_r       <= scad_pkg::SCAD_ST_IDLE;
            per_cnt_r     <= '0;
            last_per_r    <= '0;
            have_prev_r   <= 1'b0;
            edge_cnt_r    <= 4'h0;
            win_cnt_r     <= 13'h0000;
            n_r           <= 6'(`SCAD_N_RST);
            host_n_r      <= 6'(`SCAD_N_RST);
            host_set_r    <= 1'b0;
            strap_n_r     <= 6'(`SCAD_N_RST);
            strap_taken_r <= 1'b0;
            locked_r      <= 1'b0;
            lost_r        <= 1'b0;
            osc_sync_r    <= 1'b0;
            freq_r        <= 10'(`SCAD_BASE_KHZ / `SCAD_N_RST);
        end else begin
            state_r       <= state_nxt;
            per_cnt_r     <= per_cnt_nxt;
            last_per_r    <= last_per_nxt;
            have_prev_r   <= have_prev_nxt;
            edge_cnt_r    <= edge_cnt_nxt;
            win_cnt_r     <= win_cnt_nxt;
            n_r           <= n_nxt;
            host_n_r      <= host_n_nxt;
            host_set_r    <= host_set_nxt;
            strap_n_r     <= strap_n_nxt;
            strap_taken_r <= strap_taken_nxt;
            locked_r      <= locked_nxt;
            lost_r        <= lost_nxt;
            osc_sync_r    <= osc_sync_nxt;
            freq_r        <= freq_nxt;
        end
    end

    // ------------------------------------------------------------
    // Sync pin driver in output mode.
    // ------------------------------------------------------------
    logic [7:0] out_cnt_r, out_cnt_nxt;
    logic       sync_o_r,  sync_o_nxt;
    logic       sync_oe_r, sync_oe_nxt;

    always_comb begin
        sync_oe_nxt = (cfg_s == scad_pkg::SCAD_CFG_HIGH); // R11 R9
        out_cnt_nxt = out_cnt_r + 1'b1;
        sync_o_nxt  = sync_o_r;
        if (!sync_oe_nxt) begin
            out_cnt_nxt = 8'h00;
            sync_o_nxt  = 1'b0;
        end else if (out_cnt_r == 8'(`SCAD_OUT_HALF_CYC - 1)) begin
            out_cnt_nxt = 8'h00;
            sync_o_nxt  = ~sync_o_r; // R11
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            out_cnt_r <= 8'h00;
            sync_o_r  <= 1'b0;
            sync_oe_r <= 1'b0;
        end else begin
            out_cnt_r <= out_cnt_nxt;
            sync_o_r  <= sync_o_nxt;
            sync_oe_r <= sync_oe_nxt;
        end
    end

    assign osc_n      = n_r;
    assign osc_sync_p = osc_sync_r;
    assign ext_locked = locked_r;
    assign ext_lost   = lost_r;
    assign freq_khz   = freq_r;
    assign sync_o     = sync_o_r;
    assign sync_oe    = sync_oe_r;

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_no_probe_idle: assert property (state_r == scad_pkg::SCAD_ST_IDLE && !en_s |=> // R1
        state_r == scad_pkg::SCAD_ST_IDLE) else $error("probe started without enable");
    a_lock_align: assert property (locked_r && edge_p && en_s |=> osc_sync_r) // R2
        else $error("locked oscillator missed an edge");
    a_strap_low: assert property (state_r == scad_pkg::SCAD_ST_PICK && cfg_s == scad_pkg::SCAD_CFG_OPEN && // R3
        !strap_taken_r && strap_s == scad_pkg::SCAD_STRAP_LOW && !host_set_r && !host_wr && en_s
        |=> n_r == 6'h28) else $error("low strap did not give 200kHz");
    a_strap_frozen: assert property (strap_taken_r |=> strap_taken_r && $stable(strap_n_r)) // R4
        else $error("strap value changed after capture");
    a_n_range: assert property (n_r >= 6'h08 && n_r <= 6'h28) // R6
        else $error("divider out of range");
    a_host_nearest: assert property (host_wr && host_khz == 10'h32a |=> host_n_r == 6'h0a) // R7
        else $error("810kHz did not select N of 10");
    a_freq_quant: assert property (!locked_r && $stable(n_r) |-> freq_r == n_to_khz(n_r)) // R8
        else $error("read-back frequency not quantised");
    a_out_mode: assert property (cfg_s == scad_pkg::SCAD_CFG_HIGH |=> sync_oe_r ##0 !locked_r) // R11
        else $error("output mode not driving sync");
    a_loss_fallback: assert property (locked_r && en_s && !edge_p && per_cnt_r >= 13'h0258 // R12
        |=> !locked_r && lost_r && n_r == n_from_per($past(last_per_r))) else $error("no fallback on loss");
    a_lock_cause: assert property ($rose(locked_r) |-> $past(state_r) == scad_pkg::SCAD_ST_DETECT && // R13
        $past(edge_p)) else $error("lock without detection");

    c_lock: cover property ($rose(locked_r));
    c_loss: cover property ($rose(lost_r));
    c_res_pick: cover property (state_r == scad_pkg::SCAD_ST_PICK && strap_s == scad_pkg::SCAD_STRAP_RES);

endmodule

// *** tb/scad_sync_src.sv ***
// ------------------------------------------------------------
// Clock source on the shared sync line.
// ------------------------------------------------------------
module scad_sync_src (
    output logic           clk_sync,
    input  wire logic      run,
    input  wire logic [31:0] half_ns
);
    timeunit 1ns;
    timeprecision 1ps;

    // Sole driver of the line; the device's sync_o output is not connected to it here.
    // The model has no precise ramp timing mode, so it is always off.
    initial begin
        clk_sync = 1'b0;
        #7;
        forever begin
            if (run) begin
                #(half_ns) clk_sync = ~clk_sync;
            end else begin
                clk_sync = 1'b0;
                @(run);
            end
        end
    end
endmodule

// *** tb/tb_top.sv ***
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, a); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals and instances.
    // ------------------------------------------------------------
    logic                clk_sys = 1'b0;
    logic                arst_n  = 1'b0;
    logic                clk_sync;
    logic                en_pin  = 1'b0;
    logic [1:0]          cfg_pin = 2'h1;
    logic [1:0]          strap_pin = 2'h0;
    logic [4:0]          res_idx_pin = 5'h00;
    logic                host_wr = 1'b0;
    logic [9:0]          host_khz = 10'h000;
    logic                run     = 1'b0;
    int                  half    = 800;
    int                  n_fail  = 0;
    int                  tests_run = 0;
    int                  cyc     = 0;
    scad_pkg::scad_n_t   osc_n;
    scad_pkg::scad_khz_t freq_khz;
    logic                osc_sync_p;
    logic                ext_locked;
    logic                ext_lost;
    logic                sync_o;
    logic                sync_oe;

    scad_sync_src src (.clk_sync(clk_sync), .run(run), .half_ns(half));

    scad_top #(.DET_WIN_CYC(13'h7d0)) uut (
        .clk_sys(clk_sys), .arst_n(arst_n), .clk_sync(clk_sync), .en_pin(en_pin),
        .cfg_pin(cfg_pin), .strap_pin(strap_pin), .res_idx_pin(res_idx_pin),
        .host_wr(host_wr), .host_khz(host_khz), .osc_n(osc_n), .osc_sync_p(osc_sync_p),
        .ext_locked(ext_locked), .ext_lost(ext_lost), .freq_khz(freq_khz),
        .sync_o(sync_o), .sync_oe(sync_oe));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic rst(input logic [1:0] cfg, input logic [1:0] strap);
        @(posedge clk_sys);
        arst_n <= 1'b0;
        en_pin <= 1'b0;
        cfg_pin <= cfg;
        strap_pin <= strap;
        step(8);
        arst_n <= 1'b1;
        step(2);
        `CHK("osc_n rst", 6'h14, osc_n) // RESET
        `CHK("freq rst", 10'h190, freq_khz) // RESET
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------
    task automatic t_strap();
        logic [5:0] en_t [3] = '{6'h28, 6'h14, 6'h08};
        logic [9:0] ef_t [3] = '{10'h0c8, 10'h190, 10'h3e8};
        for (int i = 0; i < 3; i++) begin
            rst(2'h1, 2'(i));
            en_pin <= 1'b1;
            step(2100);
            `CHK("osc_n strap", en_t[i], osc_n)
            `CHK("freq strap", ef_t[i], freq_khz)
            `CHK("sync_oe off", 1'b0, sync_oe)
            en_pin <= 1'b0;
            strap_pin <= 2'(2 - i);
            step(5);
            en_pin <= 1'b1;
            step(2100);
            `CHK("osc_n kept", en_t[i], osc_n)
        end
        $display("test strap done");
    endtask

    task automatic t_res_host();
        logic [9:0] hk [3] = '{10'h32a, 10'h096, 10'h3ff};
        logic [5:0] hn [3] = '{6'h0a, 6'h28, 6'h08};
        logic [9:0] hf [3] = '{10'h320, 10'h0c8, 10'h3e8};
        rst(2'h1, 2'h3);
        res_idx_pin <= 5'h03;
        en_pin <= 1'b1;
        step(2100);
        `CHK("osc_n res", 6'h1e, osc_n)
        `CHK("freq res", 10'h10a, freq_khz)
        for (int i = 0; i < 3; i++) begin
            host_wr <= 1'b1;
            host_khz <= hk[i];
            step(1);
            host_wr <= 1'b0;
            step(2);
            `CHK("osc_n host", hn[i], osc_n)
            `CHK("freq host", hf[i], freq_khz)
        end
        $display("test resistor and host done");
    endtask

    task automatic t_lock();
        int cnt = 0;
        rst(2'h1, 2'h1);
        half = 15;
        run <= 1'b1;
        en_pin <= 1'b1;
        step(2100);
        `CHK("fast no lock", 1'b0, ext_locked)
        rst(2'h1, 2'h1);
        half = 800;
        en_pin <= 1'b1;
        for (int i = 0; i < 3000 && ext_locked !== 1'b1; i++) step(1);
        `CHK("locked", 1'b1, ext_locked)
        `CHK("freq locked", 10'h267, freq_khz)
        for (int i = 0; i < 800; i++) begin
            step(1);
            if (osc_sync_p === 1'b1) cnt++;
        end
        `CHK("align pulses", 1'b1, cnt >= 4 && cnt <= 6)
        run <= 1'b0;
        for (int i = 0; i < 1000 && ext_lost !== 1'b1; i++) step(1);
        `CHK("lost", 1'b1, ext_lost)
        `CHK("unlocked", 1'b0, ext_locked)
        `CHK("osc_n lost", 6'h0d, osc_n)
        `CHK("freq lost", 10'h267, freq_khz)
        $display("test lock done");
    endtask

    task automatic t_out();
        int n = 0;
        logic s0;
        rst(2'h2, 2'h0);
        en_pin <= 1'b1;
        step(4);
        `CHK("sync_oe", 1'b1, sync_oe)
        `CHK("osc_n out", 6'h14, osc_n)
        s0 = sync_o;
        for (int i = 0; i < 300 && sync_o === s0; i++) step(1);
        s0 = sync_o;
        do begin
            step(1);
            n++;
        end while (sync_o === s0 && n < 300);
        `CHK("half period", 125, n)
        rst(2'h0, 2'h0);
        en_pin <= 1'b1;
        step(2100);
        `CHK("osc_n input", 6'h14, osc_n)
        `CHK("sync_oe input", 1'b0, sync_oe)
        $display("test output done");
    endtask

    initial begin
        t_strap();
        t_res_host();
        t_lock();
        t_out();
        report_and_stop();
    end
endmodule
